// File: core/shift_if_pkg.sv
package shift_if_pkg;
  // data path widths
  localparam int DATA_W = 8;
  localparam int CNT_W = 4;
  localparam int FIFO_DEPTH = 8;
  localparam logic [CNT_W-1:0] COUNT_MAX = 4'hF;
  localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;
  localparam logic [DATA_W-1:0] BUF_RESET = 8'h00;
  // status register fields
  localparam int ST_START = 7;
  localparam int ST_WRAP = 6;
  localparam int ST_STOP = 5;
  localparam int ST_COLL = 4;
  localparam int ST_CNT_HI = 3;
  // control register fields
  localparam int CR_SIE = 7;
  localparam int CR_OIE = 6;
  localparam int CR_WM_HI = 5;
  localparam int CR_WM_LO = 4;
  localparam int CR_CS_HI = 3;
  localparam int CR_CS_LO = 2;
  localparam int CR_CLK = 1;
  localparam int CR_TC = 0;
  // wire modes in their register order
  typedef enum logic [1:0] {WM_OFF, WM_THREE, WM_TWO, WM_TWO_HOLD} wire_mode_type;
  // clock source codes
  localparam logic [1:0] CS_SOFT = 2'h0;
  localparam logic [1:0] CS_TIMER = 2'h1;
  localparam logic [1:0] CS_EXT_POS = 2'h2;
  localparam logic [1:0] CS_EXT_NEG = 2'h3;
  // data line delay for the start detector
  localparam int SYS_PERIOD_NS = 20;
  localparam int SDA_DLY_MIN_NS = 50;
  localparam int SDA_DLY_MAX_NS = 300;
  localparam int SDA_DLY_CYC = (SDA_DLY_MIN_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
endpackage

// File: core/shift_if_fifo.sv
`timescale 1ns/10ps
// ==================================================
// received byte queue
module shift_if_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] FULL_CNT = AW'(DEPTH) == 0 ? {1'b1, {AW{1'b0}}} : (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;
  // honest full and empty
  assign in_ready_o = (count_r != FULL_CNT);
  assign out_valid_o = (count_r != '0);
  assign out_data_o = mem_r[rd_ptr_r];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;
  // storage write
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_i;
    end
  end
  // pointers and fill level
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == LAST_PTR) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == LAST_PTR) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule // shift_if_fifo

// File: core/shift_if_core.sv
`timescale 1ns/10ps
// ==================================================
// universal serial shift interface, device side
module shift_if_core (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic DATA_WE_I,
  input wire logic STATUS_WE_I,
  input wire logic CONTROL_WE_I,
  input wire logic [shift_if_pkg::DATA_W-1:0] WDATA_I,
  output logic [shift_if_pkg::DATA_W-1:0] SHIFT_DATA_O,
  output logic [shift_if_pkg::DATA_W-1:0] BUFFER_O,
  output logic [shift_if_pkg::DATA_W-1:0] STATUS_O,
  output logic [shift_if_pkg::DATA_W-1:0] CONTROL_O,
  input wire logic TIMER_MATCH_I,
  input wire logic PORT_DATA_I,
  input wire logic DDR_DATA_I,
  input wire logic PORT_CLOCK_I,
  input wire logic DDR_CLOCK_I,
  input wire logic DDR_DO_I,
  input wire logic SERIAL_CLOCK_PIN_I,
  output logic SERIAL_CLOCK_PIN_O,
  output logic SERIAL_CLOCK_PIN_OE_N_O,
  input wire logic SERIAL_IN_PIN_I,
  output logic DATA_LINE_O,
  output logic DATA_LINE_OE_N_O,
  output logic DO_O,
  output logic DO_OE_N_O,
  output logic WAKE_O,
  output logic [shift_if_pkg::DATA_W-1:0] RX_DATA_O,
  output logic RX_VALID_O,
  input wire logic RX_READY_I,
  output logic RX_SPACE_O
);
  import shift_if_pkg::*;

  // ==================================================
  // declarations
  logic clk_meta_r;
  logic clk_sync_r;
  logic clk_prev_r;
  logic din_meta_r;
  logic din_sync_r;
  logic [SDA_DLY_CYC:0] din_dly_r;
  logic [DATA_W-1:0] data_r;
  logic [DATA_W-1:0] data_nxt;
  logic [DATA_W-1:0] buf_r;
  logic [CNT_W-1:0] cnt_r;
  logic start_flag_r;
  logic wrap_flag_r;
  logic stop_flag_r;
  logic start_hold_r;
  logic push_pend_r;
  logic sie_r;
  logic oie_r;
  wire_mode_type wm_r;
  logic [1:0] cs_r;
  logic toggle_r;
  logic latch_r;
  logic latch_q;
  logic latch_open;
  logic clk_rise;
  logic clk_fall;
  logic soft_stb;
  logic shift_stb;
  logic count_stb;
  logic wrap;
  logic two_wire;
  logic start_det;
  logic stop_det;
  logic fifo_ready;
  logic hold;
  logic clock_port;
  logic start_clr;
  logic wrap_clr;
  logic stop_clr;

  // ==================================================
  // pin synchronisers and edge finding
  // two flops per pin, edges from the second stage onward
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      clk_meta_r <= 1'b1;
      clk_sync_r <= 1'b1;
      clk_prev_r <= 1'b1;
      din_meta_r <= 1'b1;
      din_sync_r <= 1'b1;
    end else begin
      clk_meta_r <= SERIAL_CLOCK_PIN_I;
      clk_sync_r <= clk_meta_r;
      clk_prev_r <= clk_sync_r;
      din_meta_r <= SERIAL_IN_PIN_I;
      din_sync_r <= din_meta_r;
    end
  end

  // delayed copy of the data line for the start detector
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      din_dly_r <= '1;
    end else begin
      din_dly_r <= {din_dly_r[SDA_DLY_CYC-1:0], din_sync_r};
    end
  end

  assign clk_rise = clk_sync_r && !clk_prev_r;
  assign clk_fall = !clk_sync_r && clk_prev_r;
  assign two_wire = (wm_r == WM_TWO) || (wm_r == WM_TWO_HOLD);

  // start and stop seen against the delayed data line
  assign start_det = two_wire && clk_sync_r && din_dly_r[SDA_DLY_CYC]
                     && !din_dly_r[SDA_DLY_CYC-1];
  assign stop_det = two_wire && clk_sync_r && !din_dly_r[SDA_DLY_CYC]
                    && din_dly_r[SDA_DLY_CYC-1];

  // clockless wake: a start level straight off the pins
  assign WAKE_O = two_wire && SERIAL_CLOCK_PIN_I && !SERIAL_IN_PIN_I;

  // ==================================================
  // clock selection
  assign soft_stb = CONTROL_WE_I && WDATA_I[CR_CLK];
  // shift clock from strobe, timer or pin edge, whatever the wire mode
  always_comb begin
    case (cs_r)
      CS_SOFT: shift_stb = soft_stb;
      CS_TIMER: shift_stb = TIMER_MATCH_I;
      CS_EXT_POS: shift_stb = clk_rise;
      CS_EXT_NEG: shift_stb = clk_fall;
      default: shift_stb = 1'b0;
    endcase
  end
  // external source counts every edge
  assign count_stb = cs_r[1] ? (clk_rise || clk_fall) : shift_stb;
  assign wrap = count_stb && !STATUS_WE_I && (cnt_r == COUNT_MAX);

  // ==================================================
  // shift register and buffer
  // cpu write wins over a shift in the same cycle
  always_comb begin
    if (DATA_WE_I) begin
      data_nxt = WDATA_I;
    end else if (shift_stb) begin
      data_nxt = {data_r[DATA_W-2:0], din_sync_r};
    end else begin
      data_nxt = data_r;
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      data_r <= DATA_RESET;
    end else begin
      data_r <= data_nxt;
    end
  end

  // completed byte into the read-only copy
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      buf_r <= BUF_RESET;
    end else if (wrap) begin
      buf_r <= data_nxt;
    end
  end

  // ==================================================
  // edge counter
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      cnt_r <= '0;
    end else if (STATUS_WE_I) begin
      cnt_r <= WDATA_I[ST_CNT_HI:0];
    end else if (count_stb) begin
      cnt_r <= cnt_r + 4'h1;
    end
  end

  // ==================================================
  // flags: set wins over write-one clear
  assign start_clr = STATUS_WE_I && WDATA_I[ST_START];
  assign wrap_clr = STATUS_WE_I && WDATA_I[ST_WRAP];
  assign stop_clr = STATUS_WE_I && WDATA_I[ST_STOP];

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      start_flag_r <= 1'b0;
    end else if (start_det) begin
      start_flag_r <= 1'b1;
    end else if (start_clr) begin
      start_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      wrap_flag_r <= 1'b0;
    end else if (wrap) begin
      wrap_flag_r <= 1'b1;
    end else if (wrap_clr) begin
      wrap_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      stop_flag_r <= 1'b0;
    end else if (stop_det) begin
      stop_flag_r <= 1'b1;
    end else if (stop_clr) begin
      stop_flag_r <= 1'b0;
    end
  end

  // ==================================================
  // clock stretching
  // start hold arms at the first falling clock after a start
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      start_hold_r <= 1'b0;
    end else if (!start_flag_r || !two_wire) begin
      start_hold_r <= 1'b0;
    end else if (clk_fall) begin
      start_hold_r <= 1'b1;
    end
  end

  // byte waits here while the queue is full
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      push_pend_r <= 1'b0;
    end else if (wrap) begin
      push_pend_r <= 1'b1;
    end else if (fifo_ready) begin
      push_pend_r <= 1'b0;
    end
  end

  // any pending hold keeps the clock line low
  assign hold = two_wire && (start_hold_r || wrap_flag_r
                || (push_pend_r && !fifo_ready));

  // ==================================================
  // control register
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      sie_r <= 1'b0;
      oie_r <= 1'b0;
      wm_r <= WM_OFF;
      cs_r <= CS_SOFT;
    end else if (CONTROL_WE_I) begin
      sie_r <= WDATA_I[CR_SIE];
      oie_r <= WDATA_I[CR_OIE];
      wm_r <= wire_mode_type'(WDATA_I[CR_WM_HI:CR_WM_LO]);
      cs_r <= WDATA_I[CR_CS_HI:CR_CS_LO];
    end
  end

  // clock pin toggle strobe flips the effective port level
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      toggle_r <= 1'b0;
    end else if (CONTROL_WE_I && WDATA_I[CR_TC]) begin
      toggle_r <= !toggle_r;
    end
  end
  assign clock_port = PORT_CLOCK_I ^ toggle_r;

  // ==================================================
  // output latch on bit 7
  // open in the half cycle before the sample edge, always for internal clock
  assign latch_open = !cs_r[1] || (clk_sync_r == cs_r[0]);
  assign latch_q = latch_open ? data_r[DATA_W-1] : latch_r;

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      latch_r <= 1'b1;
    end else begin
      latch_r <= latch_q;
    end
  end

  // ==================================================
  // pins
  // data line open drain, pulled low by latch or port bit
  assign DATA_LINE_O = 1'b0;
  assign DATA_LINE_OE_N_O = !(two_wire && DDR_DATA_I
                              && (!latch_q || !PORT_DATA_I));
  // three-wire data out push-pull
  assign DO_O = latch_q;
  assign DO_OE_N_O = !((wm_r == WM_THREE) && DDR_DO_I);
  // clock line: open drain in two-wire, push-pull otherwise
  assign SERIAL_CLOCK_PIN_O = two_wire ? 1'b0 : clock_port;
  assign SERIAL_CLOCK_PIN_OE_N_O = two_wire ? !(hold || (DDR_CLOCK_I && !clock_port))
                                            : !DDR_CLOCK_I;

  // ==================================================
  // register read side
  assign SHIFT_DATA_O = data_r;
  assign BUFFER_O = buf_r;
  assign STATUS_O = {start_flag_r, wrap_flag_r, stop_flag_r,
                     two_wire && (data_r[DATA_W-1] != din_sync_r), cnt_r};
  assign CONTROL_O = {sie_r, oie_r, wm_r, cs_r, 2'h0};
  assign RX_SPACE_O = fifo_ready;

  // ==================================================
  // received byte queue
  shift_if_fifo #(
    .WIDTH(DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(CLK_SYS_I),
    .rst_i(RST_I),
    .in_valid_i(push_pend_r),
    .in_ready_o(fifo_ready),
    .in_data_i(buf_r),
    .out_valid_o(RX_VALID_O),
    .out_ready_i(RX_READY_I),
    .out_data_o(RX_DATA_O)
  );

  // ==================================================
  // checks
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (RST_I);

  sequence s_start_armed;
    start_flag_r && two_wire && clk_fall && !start_clr;
  endsequence
  sequence s_wrap_cleared;
    wrap_flag_r && wrap_clr && !wrap;
  endsequence

  chk_write_beats_shift: assert property (DATA_WE_I |=> data_r == $past(WDATA_I))
    else $error("cpu write lost to shift");
  chk_shift_left_in: assert property (shift_stb && !DATA_WE_I |=>
    data_r == {$past(data_r[DATA_W-2:0]), $past(din_sync_r)})
    else $error("shift register did not shift left");
  chk_edge_count: assert property (cs_r[1] && (clk_rise || clk_fall) && !STATUS_WE_I |=>
    cnt_r == $past(cnt_r) + 4'h1)
    else $error("external edge not counted");
  chk_wrap_flag_set: assert property (count_stb && !STATUS_WE_I && cnt_r == COUNT_MAX |=>
    wrap_flag_r && cnt_r == 4'h0)
    else $error("wrap did not set flag");
  chk_wrap_flag_clear: assert property (s_wrap_cleared |=> !wrap_flag_r)
    else $error("wrap flag not cleared");
  chk_start_flag_set: assert property (start_det |=> start_flag_r)
    else $error("start not flagged");
  chk_start_hold_low: assert property (s_start_armed |=> ##1 !SERIAL_CLOCK_PIN_OE_N_O)
    else $error("clock not held after start");
  chk_hold_release: assert property (two_wire && !start_hold_r && !wrap_flag_r && !push_pend_r
    && !DDR_CLOCK_I |-> SERIAL_CLOCK_PIN_OE_N_O)
    else $error("clock held without cause");
  chk_data_line_low: assert property (two_wire && DDR_DATA_I && !PORT_DATA_I |->
    !DATA_LINE_OE_N_O)
    else $error("data line not pulled low");
  chk_buffer_copy: assert property (wrap |=> buf_r == $past(data_nxt) ##1 (push_pend_r
    || $past(fifo_ready)))
    else $error("buffer not loaded at wrap");
endmodule // shift_if_core

// File: bench/far_master.sv
`timescale 1ns/10ps
// ==================================================
// remote two-wire bus master on open-drain lines
module far_master (
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_low_o,
  output logic sda_low_o,
  output logic stall_err_o
);
  localparam int HALF_NS = 80;
  // both lines released, no stall seen yet
  initial begin
    scl_low_o = 1'b0;
    sda_low_o = 1'b0;
    stall_err_o = 1'b0;
  end
  // data falls while the clock stays high
  task automatic frame_start();
    #(HALF_NS) sda_low_o = 1'b1;
  endtask
  // master pulls its clock low
  task automatic clock_low();
    #(HALF_NS) scl_low_o = 1'b1;
  endtask
  // let go of the clock, then wait a bounded time for it to rise
  task automatic clock_release();
    int n;
    scl_low_o = 1'b0;
    n = 0;
    while (scl_i !== 1'b1 && n < 100) begin
      #10;
      n++;
    end
    if (scl_i !== 1'b1) begin
      stall_err_o = 1'b1;
    end
  endtask
  // one bit: data changes while clock low, read back while clock high
  task automatic send_bit(input logic b, output logic seen);
    #(HALF_NS) sda_low_o = ~b;
    #(HALF_NS) clock_release();
    #(HALF_NS) seen = sda_i;
    scl_low_o = 1'b1;
  endtask
endmodule // far_master

// File: bench/test_universal_serial_shift_interface.sv
`timescale 1ns/10ps
// ==================================================
// self-checking bench for the shift interface
module test_universal_serial_shift_interface;
  import shift_if_pkg::*;
  logic CLK_SYS_I, RST_I, DATA_WE_I, STATUS_WE_I, CONTROL_WE_I;
  logic [7:0] WDATA_I, SHIFT_DATA_O, BUFFER_O, STATUS_O, CONTROL_O, RX_DATA_O;
  logic TIMER_MATCH_I, PORT_DATA_I, DDR_DATA_I, DDR_DO_I, RX_READY_I;
  logic scl_o, scl_oe_n, sda_oe_n, sda_o, DO_O, DO_OE_N_O, WAKE_O, RX_VALID_O, RX_SPACE_O;
  logic scl_low, sda_low, stall_err, din_r, scl_w, sda_w;
  int n_fail, n_compared;
  // wired-and lines with pull-ups
  assign scl_w = ~scl_low & ~(~scl_oe_n & ~scl_o);
  assign sda_w = ~sda_low & (sda_oe_n | sda_o) & din_r;
  shift_if_core DUT (.CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .DATA_WE_I(DATA_WE_I),
    .STATUS_WE_I(STATUS_WE_I), .CONTROL_WE_I(CONTROL_WE_I), .WDATA_I(WDATA_I),
    .SHIFT_DATA_O(SHIFT_DATA_O), .BUFFER_O(BUFFER_O), .STATUS_O(STATUS_O),
    .CONTROL_O(CONTROL_O), .TIMER_MATCH_I(TIMER_MATCH_I), .PORT_DATA_I(PORT_DATA_I),
    .DDR_DATA_I(DDR_DATA_I), .PORT_CLOCK_I(1'b1), .DDR_CLOCK_I(1'b0), .DDR_DO_I(DDR_DO_I),
    .SERIAL_CLOCK_PIN_I(scl_w), .SERIAL_CLOCK_PIN_O(scl_o),
    .SERIAL_CLOCK_PIN_OE_N_O(scl_oe_n), .SERIAL_IN_PIN_I(sda_w), .DATA_LINE_O(sda_o),
    .DATA_LINE_OE_N_O(sda_oe_n), .DO_O(DO_O), .DO_OE_N_O(DO_OE_N_O), .WAKE_O(WAKE_O),
    .RX_DATA_O(RX_DATA_O), .RX_VALID_O(RX_VALID_O), .RX_READY_I(RX_READY_I),
    .RX_SPACE_O(RX_SPACE_O));
  far_master u_far (.scl_i(scl_w), .sda_i(sda_w), .scl_low_o(scl_low), .sda_low_o(sda_low),
    .stall_err_o(stall_err));
  // system clock, 20 ns
  initial begin
    CLK_SYS_I = 1'b0;
    forever #10 CLK_SYS_I = ~CLK_SYS_I;
  end
  // ==================================================
  // shared tasks
  task automatic conclude();
    if (n_fail == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic settle();
    @(negedge CLK_SYS_I);
  endtask
  task automatic do_reset();
    RST_I <= 1'b1;
    repeat (4) @(posedge CLK_SYS_I);
    RST_I <= 1'b0;
    @(posedge CLK_SYS_I);
  endtask
  // write strobes: mask bit 0 data, 1 status, 2 control
  task automatic wr(input logic [2:0] mask, input logic [7:0] v);
    @(posedge CLK_SYS_I);
    WDATA_I <= v;
    DATA_WE_I <= mask[0];
    STATUS_WE_I <= mask[1];
    CONTROL_WE_I <= mask[2];
    @(posedge CLK_SYS_I);
    DATA_WE_I <= 1'b0;
    STATUS_WE_I <= 1'b0;
    CONTROL_WE_I <= 1'b0;
  endtask
  // ==================================================
  // scenarios
  task automatic t_reset_and_soft();
    do_reset();
    settle();
    chk8(STATUS_O, 8'h00);
    chk8(CONTROL_O, 8'h00);
    chk8(BUFFER_O, 8'h00);
    wr(3'h4, 8'h10);
    wr(3'h1, 8'hA5);
    wr(3'h4, 8'h12);
    settle();
    chk8(SHIFT_DATA_O, 8'h4B);
    chk8({4'h0, STATUS_O[3:0]}, 8'h01);
    chk8(CONTROL_O, 8'h10);
    wr(3'h5, 8'h12);
    settle();
    chk8(SHIFT_DATA_O, 8'h12);
    wr(3'h2, 8'h0F);
    wr(3'h4, 8'h12);
    repeat (2) settle();
    chk1(STATUS_O[ST_WRAP], 1'b1);
    chk8(BUFFER_O, 8'h25);
    wr(3'h2, 8'h40);
    settle();
    chk1(STATUS_O[ST_WRAP], 1'b0);
    wr(3'h4, 8'h14);
    @(posedge CLK_SYS_I);
    TIMER_MATCH_I <= 1'b1;
    @(posedge CLK_SYS_I);
    TIMER_MATCH_I <= 1'b0;
    settle();
    chk8(SHIFT_DATA_O, 8'h4B);
    wr(3'h4, 8'h10);
    wr(3'h1, 8'h80);
    @(posedge CLK_SYS_I);
    DDR_DO_I <= 1'b1;
    settle();
    chk1(DO_O, 1'b1);
    chk1(DO_OE_N_O, 1'b0);
    wr(3'h1, 8'h00);
    @(posedge CLK_SYS_I);
    DDR_DO_I <= 1'b0;
    settle();
    chk1(DO_O, 1'b0);
    chk1(DO_OE_N_O, 1'b1);
  endtask
  task automatic t_edges();
    do_reset();
    wr(3'h4, 8'h08);
    wr(3'h2, 8'h0F);
    u_far.clock_low();
    repeat (6) settle();
    chk1(STATUS_O[ST_WRAP], 1'b1);
    wr(3'h2, 8'h40);
    u_far.clock_release();
    repeat (6) settle();
    chk8({4'h0, STATUS_O[3:0]}, 8'h01);
  endtask
  task automatic t_fifo();
    logic [7:0] exp_q[$];
    logic [7:0] k;
    do_reset();
    din_r <= 1'b0;
    wr(3'h4, 8'h10);
    for (int i = 1; i <= 9; i++) begin
      wr(3'h1, 8'(i));
      wr(3'h2, 8'h0F);
      wr(3'h4, 8'h12);
      exp_q.push_back(8'(i << 1));
    end
    repeat (3) settle();
    chk1(RX_SPACE_O, 1'b0);
    @(posedge CLK_SYS_I);
    RX_READY_I <= 1'b1;
    k = 8'h00;
    for (int c = 0; c < 60 && k < 8'h09; c++) begin
      settle();
      if (RX_VALID_O === 1'b1) begin
        chk8(RX_DATA_O, exp_q[k]);
        k++;
      end
    end
    chk8(k, 8'h09);
    settle();
    chk1(RX_VALID_O, 1'b0);
    din_r <= 1'b1;
  endtask
  task automatic t_two_wire();
    logic seen;
    logic [7:0] addr;
    addr = 8'hA5;
    do_reset();
    RX_READY_I <= 1'b0;
    wr(3'h4, 8'h28);
    u_far.frame_start();
    repeat (8) settle();
    chk1(STATUS_O[ST_START], 1'b1);
    chk1(WAKE_O, 1'b1);
    u_far.clock_low();
    repeat (8) settle();
    chk1(scl_oe_n, 1'b0);
    wr(3'h2, 8'h80);
    repeat (2) settle();
    chk1(scl_oe_n, 1'b1);
    for (int b = 7; b >= 0; b--) begin
      u_far.send_bit(addr[b], seen);
    end
    repeat (8) settle();
    chk1(stall_err, 1'b0);
    chk8(SHIFT_DATA_O, addr);
    chk8(BUFFER_O, addr);
    chk1(scl_oe_n, 1'b0);
    chk8(RX_DATA_O, addr);
    @(posedge CLK_SYS_I);
    DDR_DATA_I <= 1'b1;
    PORT_DATA_I <= 1'b0;
    settle();
    chk1(sda_oe_n, 1'b0);
    @(posedge CLK_SYS_I);
    PORT_DATA_I <= 1'b1;
    settle();
    chk1(sda_oe_n, 1'b1);
    wr(3'h1, 8'h00);
    wr(3'h2, 8'h4E);
    settle();
    chk1(sda_oe_n, 1'b0);
    u_far.send_bit(1'b1, seen);
    repeat (8) settle();
    chk1(seen, 1'b0);
    chk1(scl_oe_n, 1'b0);
    u_far.clock_release();
    chk1(stall_err, 1'b1);
    wr(3'h2, 8'h40);
    repeat (2) settle();
    chk1(scl_oe_n, 1'b1);
  endtask
  // ==================================================
  // main sequence and watchdog
  initial begin
    n_fail = 0;
    n_compared = 0;
    RST_I = 1'b1;
    DATA_WE_I = 1'b0;
    STATUS_WE_I = 1'b0;
    CONTROL_WE_I = 1'b0;
    WDATA_I = 8'h00;
    TIMER_MATCH_I = 1'b0;
    PORT_DATA_I = 1'b1;
    DDR_DATA_I = 1'b0;
    DDR_DO_I = 1'b0;
    RX_READY_I = 1'b0;
    din_r = 1'b1;
    t_reset_and_soft();
    t_edges();
    t_fifo();
    t_two_wire();
    conclude();
  end
  // cuts a hung run short
  initial begin
    #200000;
    n_fail++;
    conclude();
  end
endmodule // test_universal_serial_shift_interface
